// *** bench/pbl_boot_loader_props.sv ***
// concurrent checks on the boot loader ports
`timescale 1ns/1ps
`include "pbl_consts.vh"
module pbl_boot_loader_props (
    input wire        clk_sys,
    input wire        rst,
    input wire        ext_ack,
    input wire        boot_select_override,
    input wire        rd_strobe,
    input wire [31:0] ext_addr,
    input wire        boot_mem_select_out,
    input wire        boot_mem_select_oe,
    input wire        mem_select_enable,
    input wire        core_idle,
    input wire        boot_mode_host,
    input wire        boot_done,
    input wire [15:0] ext_byte_count,
    input wire [15:0] dma_word_count,
    input wire [1:0]  eff_pack_mode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // prom byte access shape
    strobe_len_a: assert property ($rose(rd_strobe) |-> rd_strobe[*7])
        else $error("read strobe shorter than seven cycles");
    addr_step_a: assert property ($fell(rd_strobe) |->
        ext_addr == $past(ext_addr) + 32'h1)
        else $error("prom address did not step by one");
    cnt_step_a: assert property ($fell(rd_strobe) |->
        ext_byte_count == $past(ext_byte_count) - 16'h1)
        else $error("byte count did not step down");
    sel_drive_a: assert property (rd_strobe |->
        !boot_mem_select_out && boot_mem_select_oe && !mem_select_enable)
        else $error("prom select wrong during access");
    core_idle_a: assert property (rd_strobe |-> core_idle)
        else $error("core running during prom boot");
    stall_hold_a: assert property (!ext_ack[*5] ##0 rd_strobe |=>
        rd_strobe && $stable(ext_addr))
        else $error("access ended without acknowledge");
    pack_force_a: assert property (boot_select_override |->
        eff_pack_mode == `PBL_PACK_8_48)
        else $error("byte packing not forced");
    done_zero_a: assert property ($rose(boot_done) && !boot_mode_host |->
        ext_byte_count == 16'h0 && dma_word_count == 16'h0)
        else $error("boot done with counts left");
    host_quiet_a: assert property (boot_mode_host |->
        !rd_strobe && !boot_mem_select_oe)
        else $error("host boot started a prom access");
    core_no_sel_a: assert property (boot_select_override && boot_done &&
        !rd_strobe |-> boot_mem_select_out)
        else $error("boot select asserted for core access");
    rst_init_a: assert property (disable iff (1'b0) rst |=>
        ext_byte_count == `PBL_BYTE_COUNT_INIT &&
        dma_word_count == `PBL_WORD_COUNT_INIT && core_idle)
        else $error("reset counts wrong");

    // main scenarios reached
    cover property ($fell(rd_strobe));
    cover property ($rose(boot_done) && !boot_mode_host);
    cover property (rd_strobe && !ext_ack);
endmodule // pbl_boot_loader_props

bind pbl_boot_loader pbl_boot_loader_props u_props (.*);

// *** bench/pbl_boot_loader_tb.sv ***
// self-checking bench for the power-up boot loader
`timescale 1ns/1ps
`include "pbl_consts.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module pbl_boot_loader_tb;
    logic clk_sys = 0, rst = 1, ce = 1, ext_ack = 1, rd_req = 0, rd_d = 0;
    logic prom_boot_strap = 1, serial_boot_strap = 0, boot_mem_select_in = 0;
    logic core_ext_access = 0, boot_select_override = 0, wait_mode_wr = 0;
    logic kernel_ctrl_wr = 0, host_bus_request = 0, host_buf_wr = 0;
    logic boot_mem_select_out, boot_mem_select_oe, mem_select_enable;
    logic rd_strobe, core_idle, boot_mode_prom, boot_mode_host, boot_done;
    logic data_type_select, other_dma_block, host_bus_grant, host_ready;
    logic pack_mismatch;
    logic [1:0]  variant_sel = 0, pack_mode_field = 0, host_pack_select = 0;
    logic [1:0]  wait_mode_wr_data = 0, unbanked_delay_mode, eff_pack_mode;
    logic [2:0]  unbanked_delay_count;
    logic [7:0]  mem_rd_addr = 0, salt = 0;
    logic [15:0] kernel_ctrl_data = 0, host_buf_data = 0, ext_byte_count;
    logic [15:0] dma_word_count, dma_channel_control, hdata [0:255];
    logic [19:0] program_counter;
    logic [31:0] ext_addr, a;
    logic [47:0] mem_rd_data, e, m, exp_q [$], msk_q [$];
    logic [63:0] ext_data_in;
    integer error_cnt = 0, checked = 0, i, n, vi;

    always #2 clk_sys = ~clk_sys;

    pbl_boot_loader u_pbl_boot_loader (.*);
    pbl_prom_model u_pbl_prom_model (.clk_sys(clk_sys),
        .chip_sel_n(boot_mem_select_out), .rd_strobe(rd_strobe),
        .ext_addr(ext_addr), .variant_sel(variant_sel), .salt(salt),
        .ext_data_in(ext_data_in));

    function automatic [47:0] prom_word(input [31:0] b, input integer w);
        integer k;
        for (k = 0; k < 6; k++)
            prom_word[8*k +: 8] = u_pbl_prom_model.byte_at(b + 6*w + k, salt);
    endfunction

    task tick(input integer c);
        repeat (c) @(negedge clk_sys);
    endtask

    task do_reset(input logic p, input logic s, input logic b);
        prom_boot_strap = p;
        serial_boot_strap = s;
        boot_mem_select_in = b;
        tick(4);
        rst = 1;
        tick(4);
        rst = 0;
    endtask

    // request a memory word and note its expected value
    task mem_check(input integer w, input [47:0] x, input [47:0] k);
        mem_rd_addr = w[7:0];
        rd_req = 1;
        exp_q.push_back(x);
        msk_q.push_back(k);
        tick(1);
    endtask

    // read data lands one cycle after the request
    always @(posedge clk_sys) rd_d <= rd_req;
    always @(negedge clk_sys) begin
        if (rd_d) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            `CHK(mem_rd_data & m, e & m)
        end
    end

    task prom_run(input logic [1:0] v);
        logic [31:0] base;
        logic [19:0] vec;
        base = v == 1 ? `PBL_BASE_V1 : v == 2 ? `PBL_BASE_V2 : `PBL_BASE_V0;
        vec = v == 1 ? `PBL_RESET_VEC_V1 : v == 2 ? `PBL_RESET_VEC_V2
            : `PBL_RESET_VEC_V0;
        variant_sel = v;
        salt = $urandom;
        do_reset(1, 0, 0);
        for (i = 0; i < 50 && rd_strobe !== 1'b1; i++) tick(1);
        `CHK(ext_addr, base)
        `CHK(program_counter, vec)
        `CHK({boot_mode_prom, core_idle, mem_select_enable}, 3'h6)
        `CHK(unbanked_delay_mode, `PBL_WAIT_MODE_BOTH)
        `CHK(unbanked_delay_count, `PBL_WAIT_STATES)
        if (v == 2) begin
            ce = 0;
            tick(10);
            `CHK(ext_addr, base)
            ce = 1;
        end
        if (v == 0) begin
            tick(100);
            ext_ack = 0;
            tick(12);
            a = ext_addr;
            tick(8);
            `CHK({rd_strobe, ext_addr}, {1'b1, a})
            ext_ack = 1;
        end
        for (i = 0; i < 20000 && boot_done !== 1'b1; i++) tick(1);
        `CHK(program_counter, vec + 20'h1)
        for (i = 0; i < 40; i++) begin
            n = i < 2 ? i * 255 : $urandom_range(255);
            mem_check(n, prom_word(base, n), {48{1'b1}});
        end
        rd_req = 0;
        tick(2);
    endtask

    task summarize;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // watchdog against a hung boot
    initial begin
        repeat (100000) @(posedge clk_sys);
        error_cnt++;
        $display("Error %0t: watchdog expired", $time);
        summarize;
    end

    // main sequence: prom boot per variant, then host boot
    initial begin
        n = $urandom(85875);
        host_pack_select = $urandom;
        for (vi = 2; vi >= 0; vi--) prom_run(vi[1:0]);
        boot_select_override = 1;
        core_ext_access = 1;
        tick(6);
        `CHK({boot_mem_select_out, eff_pack_mode}, {1'b1, `PBL_PACK_8_48})
        `CHK(other_dma_block, 1'b1)
        boot_select_override = 0;
        tick(6);
        `CHK({mem_select_enable, boot_mem_select_out, other_dma_block}, 3'h6)
        wait_mode_wr_data = `PBL_WAIT_MODE_INT;
        wait_mode_wr = 1;
        tick(1);
        wait_mode_wr = 0;
        tick(2);
        `CHK(unbanked_delay_mode, `PBL_WAIT_MODE_INT)
        core_ext_access = 0;
        do_reset(0, 0, 1);
        tick(10);
        `CHK({boot_mode_host, boot_mode_prom, core_idle}, 3'h5)
        `CHK(program_counter, `PBL_RESET_VEC_V0)
        `CHK({data_type_select, dma_channel_control[0]}, 2'h3)
        `CHK(eff_pack_mode, `PBL_PACK_16_48)
        `CHK(pack_mismatch, host_pack_select != `PBL_PACK_16_48)
        host_buf_data = 16'h5a5a;
        host_buf_wr = 1;
        tick(1);
        host_buf_wr = 0;
        host_bus_request = 1;
        for (i = 0; i < 100 && !(host_bus_grant && host_ready); i++) tick(1);
        `CHK({host_bus_grant, host_ready}, 2'h3)
        for (i = 0; i < 256; i++) begin
            hdata[i] = $urandom;
            host_buf_data = hdata[i];
            host_buf_wr = 1;
            tick(1);
            host_buf_wr = 0;
            tick(3);
        end
        `CHK({boot_done, dma_word_count}, 17'h10000)
        for (i = 0; i < 16; i++) mem_check(i * 17, hdata[i * 17], 48'hffff);
        rd_req = 0;
        kernel_ctrl_data = `PBL_KERNEL_DMA_CTRL;
        kernel_ctrl_wr = 1;
        tick(1);
        kernel_ctrl_wr = 0;
        tick(2);
        `CHK(dma_channel_control, 16'h00a1)
        // master downloads unpacked words
        kernel_ctrl_data = {8'h0, `PBL_PACK_NONE, 6'h21};
        kernel_ctrl_wr = 1;
        tick(1);
        kernel_ctrl_wr = 0;
        tick(2);
        `CHK(eff_pack_mode, `PBL_PACK_NONE)
        summarize;
    end
endmodule // pbl_boot_loader_tb

// *** bench/pbl_prom_model.sv ***
// byte-wide boot prom model on the external data bus
`timescale 1ns/1ps
module pbl_prom_model (
    input  wire        clk_sys,
    input  wire        chip_sel_n,
    input  wire        rd_strobe,
    input  wire [31:0] ext_addr,
    input  wire [1:0]  variant_sel,
    input  wire [7:0]  salt,
    output reg  [63:0] ext_data_in
);
    reg [63:0] junk_reg = 64'h0123456789abcdef;

    function automatic [7:0] byte_at(input [31:0] a, input [7:0] s);
        byte_at = a[7:0] ^ {a[10:8], 5'h00} ^ s;
    endfunction

    // undriven lanes shift one bit every cycle
    always @(posedge clk_sys) begin
        junk_reg <= {junk_reg[62:0], ~junk_reg[63]};
    end

    // prom drives its lane only while selected and read
    always @* begin
        ext_data_in = junk_reg;
        if (!chip_sel_n && rd_strobe) begin
            case (variant_sel)
                2'h1: ext_data_in[7:0] = byte_at(ext_addr, salt);
                2'h2: ext_data_in[39:32] = byte_at(ext_addr, salt);
                default: ext_data_in[23:16] = byte_at(ext_addr, salt);
            endcase
        end
    end
endmodule // pbl_prom_model

// *** pkg/pbl_consts.vh ***
// constants for the power-up boot loader
`ifndef PBL_CONSTS_VH
`define PBL_CONSTS_VH
`define PBL_WORD_COUNT_INIT   16'h0100
`define PBL_BYTE_COUNT_INIT   16'h0600
`define PBL_BYTES_PER_WORD    3'h6
`define PBL_WAIT_STATES       3'h6
`define PBL_ACCESS_CYCLES     3'h7
`define PBL_WAIT_MODE_BOTH    2'h2
`define PBL_WAIT_MODE_INT     2'h1
`define PBL_BASE_V0           32'h00400000
`define PBL_BASE_V1           32'h00000000
`define PBL_BASE_V2           32'h00800000
`define PBL_RESET_VEC_V0      20'h20004
`define PBL_RESET_VEC_V1      20'h08004
`define PBL_RESET_VEC_V2      20'h40004
`define PBL_KERNEL_START_V0   20'h20005
`define PBL_KERNEL_START_V1   20'h08005
`define PBL_KERNEL_START_V2   20'h40005
`define PBL_PACK_16_48        2'h1
`define PBL_PACK_8_48         2'h3
`define PBL_PACK_NONE         2'h0
`define PBL_KERNEL_DMA_CTRL   16'h00a1
`define PBL_HOST_DMA_CTRL_V0  16'h00a1
`define PBL_MEM_DEPTH_LOG2    8
`endif

// *** rtl/pbl_boot_loader.v ***
// power-up boot sequencer with prom packing dma and host boot setup
// Summary of operation
// - prom strap high, serial low selects prom
// - byte count loads 0x600 at reset
// - boot select drives prom chip select
// - core idles, counter at reset vector
// - six bytes packed low first, 256 words
// - read strobe lasts seven cycles per byte
// - byte lane chosen by device variant
// - address starts at variant base, increments
// - other memory selects held inactive
// - both counts decrement, stop, resume kernel
// - clearing override restores normal selects
// - override forces byte packing mode
// - override blocks other three dma channels, only while dma_channel_control[0] is set
// - override gates prom select with rd_strobe, held low after boot
// - low acknowledge keeps inserting wait states
// - host boot waits as bus slave
// - host boot counter at variant reset
// - host boot zeroes byte count, no dma
// - host dma control reset value set
// - host pack select matches pack mode; a mismatch is only flagged on pack_mismatch
// - stop after 256, kernel reloads control
`timescale 1ns/1ps
`include "pbl_consts.vh"
module pbl_boot_loader (
    clk_sys,
    rst,
    ce,
    variant_sel,
    prom_boot_strap,
    serial_boot_strap,
    boot_mem_select_in,
    ext_ack,
    ext_data_in,
    core_ext_access,
    boot_select_override,
    pack_mode_field,
    host_pack_select,
    wait_mode_wr,
    wait_mode_wr_data,
    kernel_ctrl_wr,
    kernel_ctrl_data,
    host_bus_request,
    host_buf_wr,
    host_buf_data,
    mem_rd_addr,
    mem_rd_data,
    boot_mem_select_out,
    boot_mem_select_oe,
    mem_select_enable,
    rd_strobe,
    ext_addr,
    core_idle,
    program_counter,
    boot_mode_prom,
    boot_mode_host,
    boot_done,
    ext_byte_count,
    dma_word_count,
    dma_channel_control,
    data_type_select,
    eff_pack_mode,
    other_dma_block,
    unbanked_delay_mode,
    unbanked_delay_count,
    host_bus_grant,
    host_ready,
    pack_mismatch
);
    input  wire        clk_sys;
    input  wire        rst;
    input  wire        ce;
    input  wire [1:0]  variant_sel;
    input  wire        prom_boot_strap;
    input  wire        serial_boot_strap;
    input  wire        boot_mem_select_in;
    input  wire        ext_ack;
    input  wire [63:0] ext_data_in;
    input  wire        core_ext_access;
    input  wire        boot_select_override;
    input  wire [1:0]  pack_mode_field;
    input  wire [1:0]  host_pack_select;
    input  wire        wait_mode_wr;
    input  wire [1:0]  wait_mode_wr_data;
    input  wire        kernel_ctrl_wr;
    input  wire [15:0] kernel_ctrl_data;
    input  wire        host_bus_request;
    input  wire        host_buf_wr;
    input  wire [15:0] host_buf_data;
    input  wire [7:0]  mem_rd_addr;
    output wire [47:0] mem_rd_data;
    output reg         boot_mem_select_out;
    output reg         boot_mem_select_oe;
    output reg         mem_select_enable;
    output reg         rd_strobe;
    output reg  [31:0] ext_addr;
    output reg         core_idle;
    output reg  [19:0] program_counter;
    output reg         boot_mode_prom;
    output reg         boot_mode_host;
    output reg         boot_done;
    output reg  [15:0] ext_byte_count;
    output reg  [15:0] dma_word_count;
    output reg  [15:0] dma_channel_control;
    output wire        data_type_select;
    output wire [1:0]  eff_pack_mode;
    output wire        other_dma_block;
    output reg  [1:0]  unbanked_delay_mode;
    output wire [2:0]  unbanked_delay_count;
    output reg         host_bus_grant;
    output reg         host_ready;
    output wire        pack_mismatch;

    localparam ST_RESET = 3'h0;
    localparam ST_START = 3'h1;
    localparam ST_READ  = 3'h2;
    localparam ST_STORE = 3'h3;
    localparam ST_PDONE = 3'h4;
    localparam ST_HOST  = 3'h5;
    localparam ST_NOBT  = 3'h6;

    // variant lookups
    function [31:0] base_addr;
        input [1:0] v;
        begin
            case (v)
                2'h1:    base_addr = `PBL_BASE_V1;
                2'h2:    base_addr = `PBL_BASE_V2;
                default: base_addr = `PBL_BASE_V0;
            endcase
        end
    endfunction

    function [19:0] reset_vec;
        input [1:0] v;
        begin
            case (v)
                2'h1:    reset_vec = `PBL_RESET_VEC_V1;
                2'h2:    reset_vec = `PBL_RESET_VEC_V2;
                default: reset_vec = `PBL_RESET_VEC_V0;
            endcase
        end
    endfunction

    function [19:0] kern_start;
        input [1:0] v;
        begin
            case (v)
                2'h1:    kern_start = `PBL_KERNEL_START_V1;
                2'h2:    kern_start = `PBL_KERNEL_START_V2;
                default: kern_start = `PBL_KERNEL_START_V0;
            endcase
        end
    endfunction

    function [7:0] lane_byte;
        input [1:0]  v;
        input [63:0] d;
        begin
            case (v)
                2'h1:    lane_byte = d[7:0];
                2'h2:    lane_byte = d[39:32];
                default: lane_byte = d[23:16];
            endcase
        end
    endfunction

    // three-stage pin synchronisers
    reg [2:0] pb_sync_reg;
    reg [2:0] sb_sync_reg;
    reg [2:0] bm_sync_reg;
    reg [2:0] ack_sync_reg;
    reg [2:0] hbr_sync_reg;
    reg       pb_reg;
    reg       sb_reg;
    reg       bm_reg;
    reg       ack_reg;
    reg       hbr_reg;

    always @(posedge clk_sys) begin
        if (rst) begin
            pb_sync_reg  <= 3'h0;
            sb_sync_reg  <= 3'h0;
            bm_sync_reg  <= 3'h0;
            ack_sync_reg <= 3'h7;
            hbr_sync_reg <= 3'h0;
            pb_reg       <= 1'b0;
            sb_reg       <= 1'b0;
            bm_reg       <= 1'b0;
            ack_reg      <= 1'b1;
            hbr_reg      <= 1'b0;
        end else if (ce) begin
            pb_sync_reg  <= {pb_sync_reg[1:0], prom_boot_strap};
            sb_sync_reg  <= {sb_sync_reg[1:0], serial_boot_strap};
            bm_sync_reg  <= {bm_sync_reg[1:0], boot_mem_select_in};
            ack_sync_reg <= {ack_sync_reg[1:0], ext_ack};
            hbr_sync_reg <= {hbr_sync_reg[1:0], host_bus_request};
            if (pb_sync_reg[1] == pb_sync_reg[2])
                pb_reg <= pb_sync_reg[2];
            if (sb_sync_reg[1] == sb_sync_reg[2])
                sb_reg <= sb_sync_reg[2];
            if (bm_sync_reg[1] == bm_sync_reg[2])
                bm_reg <= bm_sync_reg[2];
            if (ack_sync_reg[1] == ack_sync_reg[2])
                ack_reg <= ack_sync_reg[2];
            if (hbr_sync_reg[1] == hbr_sync_reg[2])
                hbr_reg <= hbr_sync_reg[2];
        end
    end

    reg [2:0]  state_reg;
    reg [1:0]  settle_reg;
    reg [2:0]  cyc_reg;
    reg [2:0]  byte_idx_reg;
    reg [47:0] pack_reg;
    reg [7:0]  wr_addr_reg;
    reg        wr_en_reg;
    reg [47:0] wr_data_reg;

    // strobe rises in count zero, so the access ends at count seven
    wire       acc_last = (cyc_reg == `PBL_ACCESS_CYCLES);
    wire [7:0] cur_byte = lane_byte(variant_sel, ext_data_in);
    wire       wait_ack = (unbanked_delay_mode == `PBL_WAIT_MODE_BOTH);

    assign unbanked_delay_count = `PBL_WAIT_STATES;
    assign data_type_select     = dma_channel_control[5];
    // override forces byte packing
    assign eff_pack_mode = boot_select_override ? `PBL_PACK_8_48 :
                           dma_channel_control[7:6];
    assign other_dma_block = boot_select_override &
                             dma_channel_control[0];
    assign pack_mismatch = boot_mode_host &
                           (host_pack_select != eff_pack_mode);

    // boot sequencer and packing dma
    always @(posedge clk_sys) begin
        if (rst) begin
            state_reg           <= ST_RESET;
            settle_reg          <= 2'h0;
            cyc_reg             <= 3'h0;
            byte_idx_reg        <= 3'h0;
            pack_reg            <= 48'h0;
            wr_addr_reg         <= 8'h0;
            wr_en_reg           <= 1'b0;
            wr_data_reg         <= 48'h0;
            boot_mem_select_out <= 1'b1;
            boot_mem_select_oe  <= 1'b0;
            mem_select_enable   <= 1'b0;
            rd_strobe           <= 1'b0;
            ext_addr            <= 32'h0;
            core_idle           <= 1'b1;
            program_counter     <= 20'h0;
            boot_mode_prom      <= 1'b0;
            boot_mode_host      <= 1'b0;
            boot_done           <= 1'b0;
            ext_byte_count      <= `PBL_BYTE_COUNT_INIT;
            dma_word_count      <= `PBL_WORD_COUNT_INIT;
            dma_channel_control <= 16'h0;
            unbanked_delay_mode <= `PBL_WAIT_MODE_BOTH;
            host_bus_grant      <= 1'b0;
            host_ready          <= 1'b0;
        end else if (ce) begin
            wr_en_reg <= 1'b0;
            if (wait_mode_wr)
                unbanked_delay_mode <= wait_mode_wr_data;
            case (state_reg)
                // let strap synchronisers fill after release
                ST_RESET: begin
                    settle_reg <= settle_reg + 2'h1;
                    if (settle_reg == 2'h3)
                        state_reg <= ST_START;
                end
                // straps taken once, mode starts next edge
                ST_START: begin
                    program_counter <= reset_vec(variant_sel);
                    if (pb_reg && !sb_reg) begin
                        state_reg <= ST_READ;
                        boot_mode_prom     <= 1'b1;
                        boot_mem_select_oe <= 1'b1;
                        mem_select_enable  <= 1'b0;
                        ext_addr <= base_addr(variant_sel);
                        dma_channel_control <= 16'h0000 |
                            {8'h0, `PBL_PACK_8_48, 6'h21};
                    end else if (!pb_reg && !sb_reg && bm_reg) begin
                        state_reg      <= ST_HOST;
                        boot_mode_host <= 1'b1;
                        program_counter <= reset_vec(variant_sel);
                        dma_channel_control <= {8'h0,
                            ((variant_sel == 2'h1) ? `PBL_PACK_8_48 :
                             `PBL_PACK_16_48), 6'h21};
                    end else begin
                        state_reg         <= ST_NOBT;
                        core_idle         <= 1'b0;
                        mem_select_enable <= 1'b1;
                    end
                end
                // one byte access, six waits plus ack
                ST_READ: begin
                    rd_strobe <= 1'b1;
                    boot_mem_select_out <= 1'b0;
                    if (!acc_last)
                        cyc_reg <= cyc_reg + 3'h1;
                    else if (!wait_ack || ack_reg) begin
                        cyc_reg   <= 3'h0;
                        rd_strobe <= 1'b0;
                        boot_mem_select_out <= 1'b1;
                        ext_addr  <= ext_addr + 32'h1;
                        ext_byte_count <= ext_byte_count - 16'h1;
                        pack_reg <= {cur_byte, pack_reg[47:8]};
                        if (byte_idx_reg == `PBL_BYTES_PER_WORD - 3'h1) begin
                            byte_idx_reg <= 3'h0;
                            state_reg    <= ST_STORE;
                        end else
                            byte_idx_reg <= byte_idx_reg + 3'h1;
                    end
                end
                // write packed word, count down words
                ST_STORE: begin
                    wr_en_reg      <= 1'b1;
                    wr_data_reg    <= pack_reg;
                    wr_addr_reg    <= wr_addr_reg + 8'h1;
                    dma_word_count <= dma_word_count - 16'h1;
                    if (dma_word_count == 16'h1 && ext_byte_count == 16'h0)
                        state_reg <= ST_PDONE;
                    else
                        state_reg <= ST_READ;
                end
                // kernel runs, override governs selects
                ST_PDONE: begin
                    boot_done       <= 1'b1;
                    core_idle       <= 1'b0;
                    program_counter <= kern_start(variant_sel);
                    if (kernel_ctrl_wr)
                        dma_channel_control <= kernel_ctrl_data;
                    // prom select needs override and rd_strobe, and rd_strobe is held low here
                    boot_mem_select_out <= ~(boot_select_override &
                        rd_strobe & ~core_ext_access);
                    boot_mem_select_oe <= boot_select_override;
                    mem_select_enable  <= ~boot_select_override;
                    rd_strobe <= 1'b0;
                end
                // slave: no dma start, grant host request
                ST_HOST: begin
                    host_bus_grant <= hbr_reg;
                    host_ready     <= hbr_reg;
                    if (kernel_ctrl_wr)
                        dma_channel_control <= kernel_ctrl_data;
                    if (host_buf_wr && host_bus_grant) begin
                        wr_en_reg   <= 1'b1;
                        wr_data_reg <= {32'h0, host_buf_data};
                        wr_addr_reg <= wr_addr_reg + 8'h1;
                        if (dma_word_count != 16'h0)
                            dma_word_count <= dma_word_count - 16'h1;
                        if (dma_word_count == 16'h1) begin
                            boot_done <= 1'b1;
                            core_idle <= 1'b0;
                        end
                    end
                    ext_byte_count <= 16'h0;
                end
                ST_NOBT: begin
                    core_idle <= 1'b0;
                end
                default: state_reg <= ST_RESET;
            endcase
        end
    end

    pbl_word_mem u_mem (
        .clk_sys (clk_sys),
        .ce      (ce),
        .wr_en   (wr_en_reg),
        .wr_addr (wr_addr_reg - 8'h1),
        .wr_data (wr_data_reg),
        .rd_addr (mem_rd_addr),
        .rd_data (mem_rd_data)
    );
endmodule // pbl_boot_loader

// *** rtl/pbl_word_mem.v ***
// boot word memory with registered read data
`timescale 1ns/1ps
module pbl_word_mem (
    clk_sys,
    ce,
    wr_en,
    wr_addr,
    wr_data,
    rd_addr,
    rd_data
);
    input  wire        clk_sys;
    input  wire        ce;
    input  wire        wr_en;
    input  wire [7:0]  wr_addr;
    input  wire [47:0] wr_data;
    input  wire [7:0]  rd_addr;
    output reg  [47:0] rd_data;

    reg [47:0] mem [0:255];

    // write port and registered read
    always @(posedge clk_sys) begin
        if (ce) begin
            if (wr_en)
                mem[wr_addr] <= wr_data;
            rd_data <= mem[rd_addr];
        end
    end
endmodule // pbl_word_mem
